// ---- bench/time_interval_counter_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("BAD %s exp %h got %h", nm, exp, got); \
    end \
end
module time_interval_counter_tb_top;
    // ------------------------------------------------------------
    // Setup
    // ------------------------------------------------------------
    // Short tick keeps the hour case near 31k cycles
    localparam int         TDIV   = 4;
    localparam logic [7:0] A_CTL  = 8'hA1;
    localparam logic [7:0] A_SUB  = 8'hA2;
    localparam logic [7:0] A_SECS = 8'hA3;
    localparam logic [7:0] A_MIN  = 8'hA4;
    localparam logic [7:0] A_HR   = 8'hA5;
    localparam logic [7:0] A_IVAL = 8'hA6;
    localparam logic [7:0] A_NONE = 8'hA7;
    logic       clk_sys   = 1'b0;
    logic       sys_rst   = 1'b1;
    logic [7:0] sfr_addr  = 8'h00;
    logic       sfr_wr    = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic       sfr_rd    = 1'b0;
    logic [7:0] rdata;
    logic       flag;
    logic [7:0] rv;
    int         errors      = 0;
    int         checks_done = 0;

    always #50 clk_sys = ~clk_sys;

    time_interval_counter #(.TICK_DIV(TDIV)) DUT (
        .clk_sys                 (clk_sys),
        .sys_rst                 (sys_rst),
        .sfr_addr                (sfr_addr),
        .sfr_wr                  (sfr_wr),
        .sfr_wdata               (sfr_wdata),
        .sfr_rd                  (sfr_rd),
        .sfr_rdata_reg           (rdata),
        .interval_match_flag_reg (flag)
    );

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge clk_sys);
        sfr_wr    = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(negedge clk_sys);
        sfr_rd   = 1'b0;
        d        = rdata;
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc

    task automatic wait_flag(input int bound);
        for (int i = 0; i < bound; i++) begin
            if (flag === 1'b1) break;
            @(negedge clk_sys);
        end
        checks_done++;
        if (flag !== 1'b1) begin
            errors++;
            $display("BAD flag wait exp 1 got %b", flag);
            tally_and_finish();
        end
    endtask : wait_flag

    task automatic poll(input logic [7:0] a, input logic [7:0] exp,
                        output logic [7:0] v);
        for (int i = 0; i < 12; i++) begin
            rd(a, v);
            if (v === exp) break;
        end
        if (v !== exp) begin
            errors++;
            $display("BAD poll exp %h got %h", exp, v);
            tally_and_finish();
        end
    endtask : poll

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Preset just below a full rollover, then let one tick cascade
    task automatic roll(input logic [7:0] h, input logic [7:0] hexp);
        logic [7:0] v;
        wr(A_CTL, 8'h40);
        wr(A_SUB, 8'h7F);
        wr(A_SECS, 8'h3B);
        wr(A_MIN, 8'h3B);
        wr(A_HR, h);
        rd(A_HR, v);
        `CHK("hours preset", h, v)
        wr(A_CTL, 8'h41);
        poll(A_SECS, 8'h00, v);
        `CHK("seconds wrap", 8'h00, v)
        rd(A_MIN, v);
        `CHK("minutes wrap", 8'h00, v)
        rd(A_HR, v);
        `CHK("hours step", hexp, v)
        wr(A_SECS, 8'h07);
        rd(A_SECS, v);
        `CHK("write while running", 8'h00, v)
        wr(A_CTL, 8'h40);
        for (int a = 8'hA2; a <= 8'hA5; a++) begin
            rd(8'(a), v);
            `CHK("stopped time", 8'h00, v)
        end
    endtask : roll

    // Interval value one: the flag marks the first selected tick
    task automatic tb_case(input logic [1:0] tb, input logic [7:0] sub,
                           input logic [7:0] s, input logic [7:0] m,
                           input int t);
        logic [7:0] v;
        wr(A_CTL, 8'h40);
        wr(A_SUB, sub);
        wr(A_SECS, s);
        wr(A_MIN, m);
        wr(A_HR, 8'h00);
        wr(A_IVAL, 8'h01);
        wr(A_CTL, {2'b01, tb, 4'b0011});
        cyc(t - 2);
        `CHK("flag early", 1'b0, flag)
        wait_flag(8);
        rd(A_CTL, v);
        `CHK("control after match", {2'b00, tb, 4'b0111}, v)
    endtask : tb_case

    initial begin
        repeat (8) @(negedge clk_sys);
        sys_rst = 1'b0;
        `CHK("flag reset", 1'b0, flag)
        rd(A_CTL, rv);
        `CHK("control reset", 8'h00, rv)
        rd(A_IVAL, rv);
        `CHK("interval reset", 8'h00, rv)
        rd(A_NONE, rv);
        `CHK("unmapped", 8'h00, rv)
        wr(A_IVAL, 8'hFF);
        rd(A_IVAL, rv);
        `CHK("interval store", 8'hFF, rv)
        wr(A_CTL, 8'hC0);
        rd(A_CTL, rv);
        `CHK("reserved bits", 8'h00, rv)
        $display("test registers done");
        roll(8'h04, 8'h05);
        roll(8'h17, 8'h00);
        $display("test time keeping done");
        tb_case(2'b00, 8'h00, 8'h00, 8'h00, TDIV);
        tb_case(2'b01, 8'd120, 8'h00, 8'h00, 8 * TDIV);
        tb_case(2'b10, 8'd124, 8'd58, 8'h00, 132 * TDIV);
        tb_case(2'b11, 8'd124, 8'd59, 8'd58, 7684 * TDIV);
        $display("test timebase done");
        wr(A_CTL, 8'h40);
        wr(A_IVAL, 8'h03);
        wr(A_CTL, 8'h43);
        cyc(2 * TDIV);
        `CHK("reload early", 1'b0, flag)
        wait_flag(2 * TDIV + 6);
        cyc(3 * TDIV);
        `CHK("flag holds", 1'b1, flag)
        wr(A_CTL, 8'h43);
        `CHK("flag cleared", 1'b0, flag)
        wait_flag(5 * TDIV + 6);
        rd(A_CTL, rv);
        `CHK("reload keeps enable", 8'h07, rv)
        $display("test reload done");
        wr(A_CTL, 8'h40);
        wr(A_IVAL, 8'h02);
        wr(A_CTL, 8'h4B);
        wait_flag(3 * TDIV + 6);
        cyc(2);
        rd(A_CTL, rv);
        `CHK("single clears enable", 8'h0D, rv)
        wr(A_CTL, 8'h49);
        cyc(4 * TDIV);
        `CHK("single stays quiet", 1'b0, flag)
        $display("test single done");
        wr(A_CTL, 8'h40);
        wr(A_IVAL, 8'h05);
        wr(A_CTL, 8'h43);
        cyc(3 * TDIV + 2);
        wr(A_CTL, 8'h41);
        cyc(2 * TDIV);
        `CHK("counter halted", 1'b0, flag)
        wr(A_CTL, 8'h43);
        cyc(3 * TDIV);
        `CHK("counter zeroed", 1'b0, flag)
        wait_flag(3 * TDIV + 8);
        $display("test enable done");
        tally_and_finish();
    end
endmodule : time_interval_counter_tb_top
`default_nettype wire

// ---- hw/tic_pkg.sv ----
package tic_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL  = 8'h00_A1;
    localparam logic [7:0] ADDR_SUBSEC   = 8'h00_A2;
    localparam logic [7:0] ADDR_SECONDS  = 8'h00_A3;
    localparam logic [7:0] ADDR_MINUTES  = 8'h00_A4;
    localparam logic [7:0] ADDR_HOURS    = 8'h00_A5;
    localparam logic [7:0] ADDR_INTERVAL = 8'h00_A6;
    localparam logic [7:0] RESET_VALUE   = 8'h00_00;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int BIT_TIME_CLOCK_ENABLE   = 0;
    localparam int BIT_INTERVAL_ENABLE   = 1;
    localparam int BIT_FLAG   = 2;
    localparam int BIT_SINGLE = 3;
    localparam int BIT_TB_LO  = 4;
    localparam int BIT_TB_HI  = 5;

    // ------------------------------------------------------------
    // Counter limits
    // ------------------------------------------------------------
    localparam logic [7:0] SUBSEC_MAX  = 8'h00_7F;
    localparam logic [7:0] SECONDS_MAX = 8'h00_3B;
    localparam logic [7:0] MINUTES_MAX = 8'h00_3B;
    localparam logic [7:0] HOURS_MAX   = 8'h00_17;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint TICK_PERIOD_NS = 64'd7812500;
    localparam longint CLK_PERIOD_NS  = 64'd100;
    localparam int     TICK_CYCLES    =
        int'(TICK_PERIOD_NS / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        TB_SUBSEC,
        TB_SECONDS,
        TB_MINUTES,
        TB_HOURS
    } timebase_t;

endpackage : tic_pkg

// ---- hw/tick_prescaler.sv ----
`timescale 1ns/1ps
`default_nettype none
module tick_prescaler #(
    parameter int DIV = 4
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // Control and tick
    input  wire logic run,
    output var  logic tick_reg
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] count_reg;

    // Held at zero while stopped so a restart gives a full first period
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            count_reg <= '0;
            tick_reg  <= 1'b0;
        end else if (!run) begin
            count_reg <= '0;
            tick_reg  <= 1'b0;
        end else begin
            tick_reg  <= (count_reg == LAST);
            count_reg <= (count_reg == LAST) ? '0 : count_reg + W'(1);
        end
    end
endmodule : tick_prescaler
`default_nettype wire

// ---- hw/time_interval_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
module time_interval_counter
#(
    parameter int TICK_DIV = tic_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    // Special function register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_rd,
    output var  logic [7:0] sfr_rdata_reg,
    // Event
    output var  logic       interval_match_flag_reg
);
    import tic_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] sub_second_count_reg;
    logic [7:0] seconds_count_reg;
    logic [7:0] minutes_count_reg;
    logic [7:0] hours_count_reg;
    logic [7:0] interval_value_reg;
    logic [7:0] interval_count_reg;
    logic [7:0] interval_count_next;
    logic       time_clock_enable_reg;
    logic       interval_enable_reg;
    logic       single_interval_reg;
    timebase_t  timebase_reg;
    logic       tick_raw;
    logic       tick_128;
    logic       sec_tick;
    logic       min_tick;
    logic       hour_tick;
    logic       sel_tick;
    logic       interval_step;
    logic       match_hit;
    logic       ctrl_wr;
    logic       time_clock_enable_falling;
    logic       time_wr_ok;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction : hit

    // ------------------------------------------------------------
    // Time keeper
    // ------------------------------------------------------------
    tick_prescaler #(
        .DIV (TICK_DIV)
    ) u_prescaler (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .run      (time_clock_enable_reg),
        .tick_reg (tick_raw)
    );

    assign ctrl_wr      = sfr_wr && hit(sfr_addr, ADDR_CONTROL);
    assign time_clock_enable_falling = ctrl_wr && time_clock_enable_reg
                          && !sfr_wdata[BIT_TIME_CLOCK_ENABLE];
    assign time_wr_ok   = sfr_wr && !time_clock_enable_reg;
    // Tick launched on the stopping edge must not count
    assign tick_128     = tick_raw && time_clock_enable_reg;
    assign sec_tick     = tick_128 && (sub_second_count_reg == SUBSEC_MAX);
    assign min_tick     = sec_tick && (seconds_count_reg == SECONDS_MAX);
    assign hour_tick    = min_tick && (minutes_count_reg == MINUTES_MAX);

    // Prescaler is stopped while disabled, so ticks only come when enabled
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sub_second_count_reg <= RESET_VALUE;
            seconds_count_reg    <= RESET_VALUE;
            minutes_count_reg    <= RESET_VALUE;
            hours_count_reg      <= RESET_VALUE;
        end else if (time_clock_enable_falling) begin
            sub_second_count_reg <= RESET_VALUE;
            seconds_count_reg    <= RESET_VALUE;
            minutes_count_reg    <= RESET_VALUE;
            hours_count_reg      <= RESET_VALUE;
        end else if (time_wr_ok) begin
            if (hit(sfr_addr, ADDR_SUBSEC))
                sub_second_count_reg <= sfr_wdata;
            if (hit(sfr_addr, ADDR_SECONDS))
                seconds_count_reg <= sfr_wdata;
            if (hit(sfr_addr, ADDR_MINUTES))
                minutes_count_reg <= sfr_wdata;
            if (hit(sfr_addr, ADDR_HOURS))
                hours_count_reg <= sfr_wdata;
        end else if (tick_128) begin
            sub_second_count_reg <= sec_tick ? RESET_VALUE
                : sub_second_count_reg + 8'h00_01;
            if (sec_tick)
                seconds_count_reg <= min_tick ? RESET_VALUE
                    : seconds_count_reg + 8'h00_01;
            if (min_tick)
                minutes_count_reg <= hour_tick ? RESET_VALUE
                    : minutes_count_reg + 8'h00_01;
            if (hour_tick)
                hours_count_reg <= (hours_count_reg == HOURS_MAX)
                    ? RESET_VALUE : hours_count_reg + 8'h00_01;
        end
    end

    // ------------------------------------------------------------
    // Control and interval value
    // ------------------------------------------------------------
    always_comb begin
        case (timebase_reg)
            TB_SUBSEC:  sel_tick = tick_128;
            TB_SECONDS: sel_tick = sec_tick;
            TB_MINUTES: sel_tick = min_tick;
            TB_HOURS:   sel_tick = hour_tick;
            default:    sel_tick = 1'b0;
        endcase
    end

    assign interval_step = sel_tick && interval_enable_reg
                           && time_clock_enable_reg;
    // Reload on the tick after a match makes each later period the value plus one tick
    assign interval_count_next = (interval_count_reg == interval_value_reg)
        ? RESET_VALUE : interval_count_reg + 8'h00_01;
    assign match_hit = interval_step
                       && (interval_count_next == interval_value_reg);

    // Reserved bits 7:6 are not stored and read back as zero
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            time_clock_enable_reg <= 1'b0;
            interval_enable_reg   <= 1'b0;
            single_interval_reg   <= 1'b0;
            timebase_reg          <= TB_SUBSEC;
        end else if (ctrl_wr) begin
            time_clock_enable_reg <= sfr_wdata[BIT_TIME_CLOCK_ENABLE];
            interval_enable_reg   <= sfr_wdata[BIT_INTERVAL_ENABLE];
            single_interval_reg   <= sfr_wdata[BIT_SINGLE];
            timebase_reg <= timebase_t'(sfr_wdata[BIT_TB_HI:BIT_TB_LO]);
        end else if (match_hit && single_interval_reg) begin
            interval_enable_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst)
            interval_value_reg <= RESET_VALUE;
        else if (sfr_wr && hit(sfr_addr, ADDR_INTERVAL))
            interval_value_reg <= sfr_wdata;
    end

    // ------------------------------------------------------------
    // Interval counter and flag
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst)
            interval_count_reg <= RESET_VALUE;
        else if (!interval_enable_reg || !time_clock_enable_reg)
            interval_count_reg <= RESET_VALUE;
        else if (match_hit && single_interval_reg)
            interval_count_reg <= RESET_VALUE;
        else if (interval_step)
            interval_count_reg <= interval_count_next;
    end

    // A match in the cycle of a clearing write still sets the flag
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst)
            interval_match_flag_reg <= 1'b0;
        else if (match_hit)
            interval_match_flag_reg <= 1'b1;
        else if (ctrl_wr)
            interval_match_flag_reg <= sfr_wdata[BIT_FLAG];
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sfr_rdata_reg <= RESET_VALUE;
        end else if (sfr_rd) begin
            case (sfr_addr)
                ADDR_CONTROL: begin
                    sfr_rdata_reg <= RESET_VALUE;
                    sfr_rdata_reg[BIT_TB_HI:BIT_TB_LO] <= timebase_reg;
                    sfr_rdata_reg[BIT_SINGLE] <= single_interval_reg;
                    sfr_rdata_reg[BIT_FLAG] <= interval_match_flag_reg;
                    sfr_rdata_reg[BIT_INTERVAL_ENABLE] <= interval_enable_reg;
                    sfr_rdata_reg[BIT_TIME_CLOCK_ENABLE] <= time_clock_enable_reg;
                end
                ADDR_SUBSEC:   sfr_rdata_reg <= sub_second_count_reg;
                ADDR_SECONDS:  sfr_rdata_reg <= seconds_count_reg;
                ADDR_MINUTES:  sfr_rdata_reg <= minutes_count_reg;
                ADDR_HOURS:    sfr_rdata_reg <= hours_count_reg;
                ADDR_INTERVAL: sfr_rdata_reg <= interval_value_reg;
                default:       sfr_rdata_reg <= RESET_VALUE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_subsec_wrap;
        tick_128 && !time_wr_ok && !time_clock_enable_falling
        && sub_second_count_reg == SUBSEC_MAX;
    endsequence

    sequence s_minute_wrap;
        s_subsec_wrap ##0 seconds_count_reg == SECONDS_MAX;
    endsequence

    AST_SUBSEC_WRAP: assert property (s_subsec_wrap |=>
        sub_second_count_reg == RESET_VALUE
        && seconds_count_reg != $past(seconds_count_reg))
        else $error("sub-second rollover did not bump seconds");

    AST_SEC_WRAP: assert property (s_minute_wrap |=>
        seconds_count_reg == RESET_VALUE
        && minutes_count_reg != $past(minutes_count_reg))
        else $error("seconds rollover did not bump minutes");

    AST_HOUR_WRAP: assert property (s_minute_wrap ##0
        minutes_count_reg == MINUTES_MAX ##0 hours_count_reg == HOURS_MAX
        |=> hours_count_reg == RESET_VALUE)
        else $error("hours did not wrap to zero");

    AST_TIME_CLOCK_ENABLE_CLEAR: assert property (time_clock_enable_falling |=>
        (sub_second_count_reg == RESET_VALUE
        && hours_count_reg == RESET_VALUE && !time_clock_enable_reg)
        ##1 (sub_second_count_reg == RESET_VALUE || $past(time_wr_ok)))
        else $error("time registers not cleared on disable");

    AST_PRESET: assert property (time_wr_ok
        && hit(sfr_addr, ADDR_SECONDS)
        |=> seconds_count_reg == $past(sfr_wdata))
        else $error("seconds preset while stopped was lost");

    AST_FLAG_SET: assert property (match_hit |=>
        interval_match_flag_reg)
        else $error("match did not set the flag");

    AST_FLAG_HOLD: assert property (interval_match_flag_reg
        && !ctrl_wr |=> interval_match_flag_reg)
        else $error("flag cleared without software");

    AST_SINGLE: assert property (match_hit && single_interval_reg
        && !ctrl_wr |=> !interval_enable_reg
        ##1 interval_count_reg == RESET_VALUE)
        else $error("single interval did not stop the counter");

    AST_RELOAD: assert property (interval_step
        && !single_interval_reg
        && interval_count_reg == interval_value_reg && !ctrl_wr
        |=> interval_count_reg == RESET_VALUE)
        else $error("counter did not restart after a match");

    AST_STOPPED: assert property (!interval_enable_reg
        |=> interval_count_reg == RESET_VALUE)
        else $error("interval counter not cleared while disabled");

    AST_TIMEBASE: assert property (interval_step
        && timebase_reg == TB_MINUTES |-> seconds_count_reg == SECONDS_MAX
        && sub_second_count_reg == SUBSEC_MAX)
        else $error("interval stepped off its timebase");
endmodule : time_interval_counter
`default_nettype wire
